// ===== shared/fbbse_regs.vh
// constants for the flag branch, bit and shift execution unit
`ifndef FBBSE_REGS_VH
`define FBBSE_REGS_VH

// --------------------------------------------------------------
// operation codes
// --------------------------------------------------------------
`define FBBSE_OP_NOP 5'h00
`define FBBSE_OP_BR_CARRY_CLEAR 5'h01
`define FBBSE_OP_BR_SAME_OR_HIGHER 5'h02
`define FBBSE_OP_BR_LOWER 5'h03
`define FBBSE_OP_BR_MINUS 5'h04
`define FBBSE_OP_BR_PLUS 5'h05
`define FBBSE_OP_BR_SIGNED_GE 5'h06
`define FBBSE_OP_BR_SIGNED_LT 5'h07
`define FBBSE_OP_BR_HALF_SET 5'h08
`define FBBSE_OP_BR_HALF_CLEAR 5'h09
`define FBBSE_OP_BR_TRANSFER_SET 5'h0a
`define FBBSE_OP_BR_IRQ_ENABLED 5'h0b
`define FBBSE_OP_BR_IRQ_DISABLED 5'h0c
`define FBBSE_OP_SET_IO_BIT 5'h0d
`define FBBSE_OP_CLEAR_IO_BIT 5'h0e
`define FBBSE_OP_LSL 5'h0f
`define FBBSE_OP_LSR 5'h10
`define FBBSE_OP_ROL 5'h11
`define FBBSE_OP_ROR 5'h12
`define FBBSE_OP_ASR 5'h13
`define FBBSE_OP_SWAP 5'h14
`define FBBSE_OP_BIT_STORE 5'h15
`define FBBSE_OP_BIT_LOAD 5'h16

// --------------------------------------------------------------
// status register field positions
// --------------------------------------------------------------
`define FBBSE_SR_C 0
`define FBBSE_SR_Z 1
`define FBBSE_SR_N 2
`define FBBSE_SR_V 3
`define FBBSE_SR_S 4
`define FBBSE_SR_H 5
`define FBBSE_SR_T 6
`define FBBSE_SR_I 7

// --------------------------------------------------------------
// reset values and timing counts
// --------------------------------------------------------------
`define FBBSE_SR_RESET 8'h00
`define FBBSE_PC_RESET 16'h0000
`define FBBSE_CYC_BR_NOT_TAKEN 2'h1
`define FBBSE_CYC_BR_TAKEN 2'h2
`define FBBSE_CYC_IO_BIT 2'h2
`define FBBSE_CYC_SINGLE 2'h1

`endif

// ===== design/fbbse_exec.v
// execution unit for flag branches, i/o bit ops, shifts and bit moves
// Functional notes
// - carry clear / same-or-higher branch jumps to pc+k+1 when c is 0
// - lower branch jumps to pc+k+1 only when c is 1
// - minus jumps on n set, plus on n clear; flags untouched
// - signed ge branch jumps when n xor v is 0
// - signed lt branch jumps when n xor v is 1
// - half carry set branch jumps when h is 1; one or two cycles
// - half carry clear branch jumps when h is 0
// - transfer set branch jumps when t is 1, no flag change
// - irq enabled / disabled branches test i flag, flags untouched
// - set / clear i/o bit forces bit b of port p, two cycles
// - logical shift left fills bit 0 with zero, updates z c n v
// - logical shift right clears bit 7, updates z c n v
// - rotate left puts old c in bit 0, old bit 7 in c
// - rotate right puts old c in bit 7, old bit 0 in c
// - arithmetic shift right keeps bit 7, updates z c n v
// - nibble swap exchanges halves, leaves flags alone
// - bit store copies source bit b into t only
// - bit load copies t into destination bit b, no flag change
`timescale 1ns/100ps
`include "fbbse_regs.vh"

module fbbse_exec (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_op_valid,
  input wire [4:0] i_op_code,
  input wire [15:0] i_pc,
  input wire [6:0] i_offset_k,
  input wire [7:0] i_reg_data,
  input wire [2:0] i_bit_sel,
  input wire [5:0] i_io_addr,
  input wire [7:0] i_io_rdata,
  input wire i_sr_load,
  input wire [7:0] i_sr_wdata,
  output wire o_op_ready,
  output reg o_done,
  output reg [1:0] o_cycles,
  output reg o_pc_load,
  output reg [15:0] o_pc_next,
  output reg o_reg_we,
  output reg [7:0] o_reg_wdata,
  output reg o_io_we,
  output reg [5:0] o_io_addr,
  output reg [7:0] o_io_wdata,
  output reg o_io_rd,
  output reg [7:0] o_status_register
);

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  // io bit ops are read-modify-write and taken branches reload pc, so
  // both hold the unit for a second cycle; everything else finishes in the issue cycle
  localparam ST_IDLE = 2'h0;
  localparam ST_IO_WRITE = 2'h1;
  localparam ST_BR_SECOND = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg io_set;
  reg [2:0] io_bit;
  reg [15:0] br_target;

  wire flag_c = o_status_register[`FBBSE_SR_C];
  wire flag_n = o_status_register[`FBBSE_SR_N];
  wire flag_v = o_status_register[`FBBSE_SR_V];
  wire flag_h = o_status_register[`FBBSE_SR_H];
  wire flag_t = o_status_register[`FBBSE_SR_T];
  wire flag_i = o_status_register[`FBBSE_SR_I];

  assign o_op_ready = (state == ST_IDLE);

  // ------------------------------------------------------------
  // branch decision
  // ------------------------------------------------------------
  reg br_op;
  reg br_take;
  wire [15:0] k_ext = {{9{i_offset_k[6]}}, i_offset_k};
  wire [15:0] target = i_pc + k_ext + 16'h0001;

  always @* begin
    br_op = 1'b1;
    br_take = 1'b0;
    case (i_op_code)
      `FBBSE_OP_BR_CARRY_CLEAR: br_take = ~flag_c;
      `FBBSE_OP_BR_SAME_OR_HIGHER: br_take = ~flag_c;
      `FBBSE_OP_BR_LOWER: br_take = flag_c;
      `FBBSE_OP_BR_MINUS: br_take = flag_n;
      `FBBSE_OP_BR_PLUS: br_take = ~flag_n;
      `FBBSE_OP_BR_SIGNED_GE: br_take = ~(flag_n ^ flag_v);
      `FBBSE_OP_BR_SIGNED_LT: br_take = flag_n ^ flag_v;
      `FBBSE_OP_BR_HALF_SET: br_take = flag_h;
      `FBBSE_OP_BR_HALF_CLEAR: br_take = ~flag_h;
      `FBBSE_OP_BR_TRANSFER_SET: br_take = flag_t;
      `FBBSE_OP_BR_IRQ_ENABLED: br_take = flag_i;
      `FBBSE_OP_BR_IRQ_DISABLED: br_take = ~flag_i;
      default: br_op = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // shifter for shifts and rotates
  // ------------------------------------------------------------
  reg sh_op;
  reg [7:0] sh_res;
  reg sh_c;

  always @* begin
    sh_op = 1'b1;
    sh_res = i_reg_data;
    sh_c = flag_c;
    case (i_op_code)
      `FBBSE_OP_LSL: begin
        sh_res = {i_reg_data[6:0], 1'b0};
        sh_c = i_reg_data[7];
      end
      `FBBSE_OP_LSR: begin
        sh_res = {1'b0, i_reg_data[7:1]};
        sh_c = i_reg_data[0];
      end
      `FBBSE_OP_ROL: begin
        sh_res = {i_reg_data[6:0], flag_c};
        sh_c = i_reg_data[7];
      end
      `FBBSE_OP_ROR: begin
        sh_res = {flag_c, i_reg_data[7:1]};
        sh_c = i_reg_data[0];
      end
      `FBBSE_OP_ASR: begin
        sh_res = {i_reg_data[7], i_reg_data[7:1]};
        sh_c = i_reg_data[0];
      end
      default: sh_op = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // bit insert and extract
  // ------------------------------------------------------------
  // one helper serves the io read-modify-write, bit load and bit
  // store, so all three agree on how bit b is numbered
  wire [7:0] io_word;
  wire [7:0] ld_word;
  wire st_bit;

  fbbse_bit_put #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_io_put (
    .i_word(i_io_rdata),
    .i_sel(io_bit),
    .i_val(io_set),
    .o_word(io_word),
    .o_bit()
  );

  fbbse_bit_put #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_ld_put (
    .i_word(i_reg_data),
    .i_sel(i_bit_sel),
    .i_val(flag_t),
    .o_word(ld_word),
    .o_bit()
  );

  fbbse_bit_put #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_st_get (
    .i_word(i_reg_data),
    .i_sel(i_bit_sel),
    .i_val(1'b0),
    .o_word(),
    .o_bit(st_bit)
  );

  // ------------------------------------------------------------
  // shift flags
  // ------------------------------------------------------------
  // s is left alone by shifts; only z c n v move
  wire sh_n = sh_res[7];
  wire sh_z = (sh_res == 8'h00);
  wire sh_v = sh_n ^ sh_c;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  wire issue = i_op_valid & o_op_ready;
  wire op_io = (i_op_code == `FBBSE_OP_SET_IO_BIT) ||
               (i_op_code == `FBBSE_OP_CLEAR_IO_BIT);
  wire op_bst = (i_op_code == `FBBSE_OP_BIT_STORE);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue && op_io) begin
          next_state = ST_IO_WRITE;
        end else if (issue && br_op && br_take) begin
          next_state = ST_BR_SECOND;
        end
      end
      ST_IO_WRITE: next_state = ST_IDLE;
      ST_BR_SECOND: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  // core-side flag writes from other units; our own ops win, bit
  // by bit, when both land in the same cycle
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_status_register <= `FBBSE_SR_RESET;
    end else begin
      if (i_sr_load) begin
        o_status_register <= i_sr_wdata;
      end
      if (issue && sh_op) begin
        o_status_register[`FBBSE_SR_C] <= sh_c;
        o_status_register[`FBBSE_SR_N] <= sh_n;
        o_status_register[`FBBSE_SR_Z] <= sh_z;
        o_status_register[`FBBSE_SR_V] <= sh_v;
      end else if (issue && op_bst) begin
        o_status_register[`FBBSE_SR_T] <= st_bit;
      end
    end
  end

  // ------------------------------------------------------------
  // issue and retire
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_IDLE;
      io_set <= 1'b0;
      io_bit <= 3'h0;
      br_target <= `FBBSE_PC_RESET;
      o_done <= 1'b0;
      o_cycles <= 2'h0;
      o_pc_load <= 1'b0;
      o_pc_next <= `FBBSE_PC_RESET;
      o_reg_we <= 1'b0;
      o_reg_wdata <= 8'h00;
      o_io_we <= 1'b0;
      o_io_addr <= 6'h00;
      o_io_wdata <= 8'h00;
      o_io_rd <= 1'b0;
    end else begin
      state <= next_state;
      o_done <= 1'b0;
      o_pc_load <= 1'b0;
      o_reg_we <= 1'b0;
      o_io_we <= 1'b0;
      o_io_rd <= 1'b0;
      case (state)
        ST_IO_WRITE: begin
          // port value is sampled now, one cycle after the read strobe
          o_io_we <= 1'b1;
          o_io_wdata <= io_word;
          o_done <= 1'b1;
          o_cycles <= `FBBSE_CYC_IO_BIT;
        end
        ST_BR_SECOND: begin
          o_pc_load <= 1'b1;
          o_pc_next <= br_target;
          o_done <= 1'b1;
          o_cycles <= `FBBSE_CYC_BR_TAKEN;
        end
        default: begin
          if (issue && br_op) begin
            // a taken branch costs a second cycle; flags stay put
            br_target <= target;
            if (!br_take) begin
              o_done <= 1'b1;
              o_cycles <= `FBBSE_CYC_BR_NOT_TAKEN;
            end
          end else if (issue && sh_op) begin
            o_reg_we <= 1'b1;
            o_reg_wdata <= sh_res;
            o_done <= 1'b1;
            o_cycles <= `FBBSE_CYC_SINGLE;
          end else if (issue) begin
            case (i_op_code)
              `FBBSE_OP_SET_IO_BIT, `FBBSE_OP_CLEAR_IO_BIT: begin
                io_set <= (i_op_code == `FBBSE_OP_SET_IO_BIT);
                io_bit <= i_bit_sel;
                o_io_addr <= i_io_addr;
                o_io_rd <= 1'b1;
              end
              `FBBSE_OP_SWAP: begin
                o_reg_we <= 1'b1;
                o_reg_wdata <= {i_reg_data[3:0], i_reg_data[7:4]};
                o_done <= 1'b1;
                o_cycles <= `FBBSE_CYC_SINGLE;
              end
              `FBBSE_OP_BIT_STORE: begin
                o_done <= 1'b1;
                o_cycles <= `FBBSE_CYC_SINGLE;
              end
              `FBBSE_OP_BIT_LOAD: begin
                o_reg_we <= 1'b1;
                o_reg_wdata <= ld_word;
                o_done <= 1'b1;
                o_cycles <= `FBBSE_CYC_SINGLE;
              end
              default: begin
                // unknown or nop codes retire silently in one cycle
                o_done <= 1'b1;
                o_cycles <= `FBBSE_CYC_SINGLE;
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule

// --------------------------------------------------------------
// bit insert and extract helper
// --------------------------------------------------------------
module fbbse_bit_put #(
  parameter WIDTH = 8,
  parameter SEL_W = 3
) (
  input wire [WIDTH-1:0] i_word,
  input wire [SEL_W-1:0] i_sel,
  input wire i_val,
  output wire [WIDTH-1:0] o_word,
  output wire o_bit
);
  wire [WIDTH-1:0] mask = {{(WIDTH-1){1'b0}}, 1'b1} << i_sel;
  assign o_word = i_val ? (i_word | mask) : (i_word & ~mask);
  assign o_bit = |(i_word & mask);
endmodule

// ===== dv/fbbse_exec_monitor.sv
// assertion checker for the flag branch, bit and shift unit
`timescale 1ns/100ps
module fbbse_exec_monitor (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_op_valid,
  input wire [4:0] i_op_code,
  input wire [15:0] i_pc,
  input wire [6:0] i_offset_k,
  input wire [7:0] i_reg_data,
  input wire i_sr_load,
  input wire o_op_ready,
  input wire o_done,
  input wire [1:0] o_cycles,
  input wire o_pc_load,
  input wire [15:0] o_pc_next,
  input wire o_reg_we,
  input wire [7:0] o_reg_wdata,
  input wire o_io_we,
  input wire o_io_rd,
  input wire [7:0] o_status_register
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  wire tk = i_op_valid && o_op_ready;
  wire [15:0] tgt = i_pc + {{9{i_offset_k[6]}}, i_offset_k} + 16'h1;
  wire sh = tk && i_op_code >= 5'hf && i_op_code <= 5'h13;
  wire [7:0] sr = o_status_register;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_br_taken;
    tk && i_op_code == 5'hb && sr[7] && !i_sr_load |=> !o_op_ready
      ##1 o_pc_load && o_done && o_pc_next == $past(tgt, 2);
  endproperty
  a_br_taken: assert property (p_br_taken)
    else $error("taken branch target wrong");
  property p_br_skip;
    tk && i_op_code == 5'h1 && sr[0] && !i_sr_load
      |=> o_done && !o_pc_load && o_cycles == 2'h1;
  endproperty
  a_br_skip: assert property (p_br_skip)
    else $error("untaken branch wrong");
  property p_pc_cost;
    o_pc_load |-> o_done && o_cycles == 2'h2;
  endproperty
  a_pc_cost: assert property (p_pc_cost)
    else $error("taken branch cost wrong");
  property p_io_seq;
    tk && (i_op_code == 5'hd || i_op_code == 5'he) |=> o_io_rd
      ##1 o_io_we && o_done && o_cycles == 2'h2;
  endproperty
  a_io_seq: assert property (p_io_seq)
    else $error("io bit sequence wrong");
  property p_lsl;
    tk && i_op_code == 5'hf
      |=> o_reg_we && o_reg_wdata == {$past(i_reg_data[6:0]), 1'b0};
  endproperty
  a_lsl: assert property (p_lsl)
    else $error("left shift wrong");
  property p_lsr;
    tk && i_op_code == 5'h10
      |=> o_reg_we && o_reg_wdata == {1'b0, $past(i_reg_data[7:1])};
  endproperty
  a_lsr: assert property (p_lsr)
    else $error("right shift wrong");
  property p_asr;
    tk && i_op_code == 5'h13 |=> o_reg_wdata == $past(
      {i_reg_data[7], i_reg_data[7:1]});
  endproperty
  a_asr: assert property (p_asr)
    else $error("arith shift wrong");
  property p_swap;
    tk && i_op_code == 5'h14 && !i_sr_load |=> $stable(sr)
      && o_reg_wdata == $past({i_reg_data[3:0], i_reg_data[7:4]});
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");
  property p_sh_flags;
    sh |=> sr[3] == (sr[2] ^ sr[0]) && sr[2] == o_reg_wdata[7]
      && sr[1] == (o_reg_wdata == 8'h0);
  endproperty
  a_sh_flags: assert property (p_sh_flags)
    else $error("shift flags wrong");
endmodule
bind fbbse_exec fbbse_exec_monitor u_mon (.*);

// ===== dv/fbbse_exec_tb_top.sv
// testbench for the flag branch, bit and shift unit
`timescale 1ns/100ps
module fbbse_exec_tb_top;
  reg i_clk_sys = 1'b0;
  reg i_rst = 1'b1;
  reg i_op_valid = 1'b0;
  reg i_sr_load = 1'b0;
  reg [4:0] i_op_code = 5'h0;
  reg [6:0] i_offset_k = 7'h0;
  reg [2:0] i_bit_sel = 3'h0;
  reg [7:0] i_reg_data = 8'h0;
  reg [7:0] i_sr_wdata = 8'h0;
  reg [7:0] i_io_rdata = 8'h81;
  reg [5:0] i_io_addr = 6'h2a;
  reg [15:0] i_pc = 16'h0100;
  wire o_op_ready, o_done, o_pc_load, o_reg_we, o_io_we, o_io_rd;
  wire [1:0] o_cycles;
  wire [5:0] o_io_addr;
  wire [15:0] o_pc_next;
  wire [7:0] o_reg_wdata, o_io_wdata, o_status_register;
  integer n_errors = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i, j;
  fbbse_exec u_dut (.*);
  always #4 i_clk_sys = ~i_clk_sys;
  // under two hundred cycles suffice, so a hang is cut at 5000
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task set_sr(input [7:0] v);
    begin
      i_sr_load = 1'b1;
      i_sr_wdata = v;
      @(negedge i_clk_sys);
      i_sr_load = 1'b0;
    end
  endtask
  // issue one op and wait a bounded time for its retire pulse
  task run(input [4:0] c, input [6:0] k, input [7:0] d, input [2:0] b);
    integer n;
    begin
      i_op_code = c;
      i_offset_k = k;
      i_reg_data = d;
      i_bit_sel = b;
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
      i_op_valid = 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 4) begin
        @(negedge i_clk_sys);
        n = n + 1;
      end
      chk(o_done, 1'b1);
    end
  endtask
  function tk(input [4:0] c, input [7:0] f);
    case (c)
      5'h1, 5'h2: tk = !f[0];
      5'h3: tk = f[0];
      5'h4: tk = f[2];
      5'h5: tk = !f[2];
      5'h6: tk = !(f[2] ^ f[3]);
      5'h7: tk = f[2] ^ f[3];
      5'h8: tk = f[5];
      5'h9: tk = !f[5];
      5'ha: tk = f[6];
      5'hb: tk = f[7];
      default: tk = !f[7];
    endcase
  endfunction
  function [8:0] sh(input [4:0] c, input [7:0] d, input ci);
    case (c)
      5'hf: sh = {d, 1'b0};
      5'h10: sh = {d[0], 1'b0, d[7:1]};
      5'h11: sh = {d, ci};
      5'h12: sh = {d[0], ci, d[7:1]};
      default: sh = {d[0], d[7], d[7:1]};
    endcase
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_branch;
    reg [7:0] f;
    reg t;
    begin
      for (i = 1; i < 13; i = i + 1)
        for (j = 0; j < 4; j = j + 1) begin
          f = j == 0 ? 8'h00 : j == 1 ? 8'hff : j == 2 ? 8'h09 : 8'h04;
          set_sr(f);
          t = tk(i[4:0], f);
          run(i[4:0], 7'h7c, 8'h0, 3'h0);
          chk(o_pc_load, t);
          chk(o_cycles, t ? 2'h2 : 2'h1);
          if (t) chk(o_pc_next, 16'h00fd);
          chk(o_status_register, f);
        end
    end
  endtask
  task t_io;
    begin
      set_sr(8'h81);
      run(5'hd, 7'h0, 8'h0, 3'h3);
      chk({o_io_we, o_io_addr, o_io_wdata}, 15'h6a89);
      run(5'he, 7'h0, 8'h0, 3'h7);
      chk(o_io_wdata, 8'h01);
      chk(o_status_register, 8'h81);
    end
  endtask
  task t_shift;
    reg [7:0] d;
    reg [8:0] r;
    reg ci;
    begin
      for (i = 15; i < 20; i = i + 1)
        for (j = 0; j < 3; j = j + 1) begin
          ci = j == 0;
          d = j == 0 ? 8'h81 : j == 1 ? 8'h01 : 8'h80;
          set_sr({7'h78, ci});
          r = sh(i[4:0], d, ci);
          run(i[4:0], 7'h0, d, 3'h0);
          chk(o_reg_wdata, r[7:0]);
          chk(o_status_register, {4'hf, r[7] ^ r[8], r[7],
            r[7:0] == 8'h0, r[8]});
        end
    end
  endtask
  task t_bits;
    begin
      set_sr(8'h00);
      run(5'h14, 7'h0, 8'h3c, 3'h0);
      chk({o_reg_wdata, o_status_register}, 16'hc300);
      run(5'h15, 7'h0, 8'h10, 3'h4);
      chk(o_status_register, 8'h40);
      run(5'h16, 7'h0, 8'h00, 3'h4);
      chk({o_reg_wdata, o_status_register}, 16'h1040);
      run(5'h15, 7'h0, 8'hef, 3'h4);
      chk(o_status_register, 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    @(negedge i_clk_sys);
    t_branch;
    t_io;
    t_shift;
    t_bits;
    stop_test;
  end
endmodule
